//--- logic/crf_refill_ctrl.sv
// Summary of operation
// - store hits write the data cache only; memory is not touched
// - dirty lines leave only on miss replacement or write-back operation
// - a written-back line is marked invalid
// - load or store miss issues a line read; data lands in the cache
// - data refill returns critical doubleword first; pipeline restarts on it
// - refill start drives the address and moves a dirty victim out
// - memory read waits for a system-clock-aligned pipeline cycle
// - narrow store miss merges bytes into the refilled doubleword
// - cache is interlocked while the line is filled and merged
// - data miss penalty is 3 + alignment + critical transfer + 1
// - clean victim on load miss is simply overwritten
// - dirty victim on load miss goes to flush buffer, then memory
// - clean-victim store miss: merged line cached and written to memory
// - dirty-victim store miss: victim flushed, merged line cached dirty
// - data refill bus budget: lead, sync, bus, memory, two beats, return
// - instruction refill returns words in order from word zero
// - instruction miss reads whole line, writes cache, then restarts
// - instruction miss penalty is 4 + alignment + line transfer + 1
// - instruction budget as data, with eight transfer cycles
// - data lines invalid/clean/dirty; instruction lines invalid/valid
// - no reset touches any line state
// - no outside path examines or alters cache state or contents
// - data tag holds 20 address bits, valid and dirty
// - data line is four words, instruction line eight
`timescale 1ns/1ps
`default_nettype none
module crf_refill_ctrl
  import crf_pkg::*;
#(
  parameter int DC_IDX_W = DC_IDX_W_DOC,
  parameter int IC_IDX_W = IC_IDX_W_DOC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // pipeline request
  input wire logic reqValid,
  input wire logic [1:0] reqOp,
  input wire logic [PADDR_W-1:0] reqAddr,
  input wire logic [DW_W-1:0] reqWdata,
  input wire logic [BE_W-1:0] reqBe,
  output logic reqReady,
  // pipeline answer
  output logic rspValid,
  output logic [DW_W-1:0] rspData,
  output logic [PEN_W-1:0] missPenalty,
  // system clock boundary marker
  input wire logic sysClkEdge,
  // memory read
  output logic memRead,
  output logic [PADDR_W-1:0] memAddr,
  output logic [3:0] memWords,
  input wire logic memBeatValid,
  input wire logic [WORD_W-1:0] memBeatData,
  // write-back
  output logic wbValid,
  output logic [PADDR_W-1:0] wbAddr,
  output logic [WORD_W-1:0] wbData,
  input wire logic wbAccept
);
  localparam int DC_LINES = 1 << DC_IDX_W;
  localparam int IC_LINES = 1 << IC_IDX_W;
  localparam int DC_LOW_W = TAG_LSB - DC_IDX_LSB;
  initial if (DC_IDX_W < DC_LOW_W || DC_IDX_W > TAG_LSB) $error("bad DC_IDX_W");
  initial if (IC_IDX_W < 1 || IC_IDX_W > PADDR_W - IC_IDX_LSB) $error("bad IC_IDX_W");

  ////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [DC_IDX_W-1:0] dcIdx(input logic [PADDR_W-1:0] a);
    return a[DC_IDX_LSB +: DC_IDX_W];
  endfunction

  function automatic logic [IC_IDX_W-1:0] icIdx(input logic [PADDR_W-1:0] a);
    return a[IC_IDX_LSB +: IC_IDX_W];
  endfunction

  function automatic logic [TAG_W-1:0] tagOf(input logic [PADDR_W-1:0] a);
    return a[TAG_LSB +: TAG_W];
  endfunction

  function automatic logic [PADDR_W-1:0] lineAddr(input logic [TAG_W-1:0] t,
                                                  input logic [DC_IDX_W-1:0] i);
    return {t, i[DC_LOW_W-1:0], 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////
  // line storage, never reset, no outside access
  crf_dstate_t dState [DC_LINES];
  logic [TAG_W-1:0] dTag [DC_LINES];
  logic [DC_LINE_W-1:0] dData [DC_LINES];
  // known at power-up so a first fetch decodes; no reset clears it
  logic iValid [IC_LINES] = '{default: 1'b0};
  logic [TAG_W-1:0] iTag [IC_LINES];
  logic [IC_LINE_W-1:0] iData [IC_LINES];

  ////////////////////////////////////////////////////////////////
  // control registers
  crf_fsm_t state_reg, stateNext;
  crf_op_t op_reg;
  logic [PADDR_W-1:0] addr_reg;
  logic [DW_W-1:0] wdata_reg;
  logic [BE_W-1:0] be_reg;
  logic [2:0] lead_reg;
  logic [3:0] beat_reg;
  logic [IC_LINE_W-1:0] line_reg;
  logic critPend_reg, victimDirty_reg, restarted_reg;
  logic [PEN_W-1:0] penCnt_reg;
  logic reqReady_reg, rspValid_reg, memRead_reg;
  logic [DW_W-1:0] rspData_reg;
  logic [PEN_W-1:0] missPenalty_reg;
  logic [PADDR_W-1:0] memAddr_reg;
  logic [3:0] memWords_reg;

  ////////////////////////////////////////////////////////////////
  // lookup on the incoming request
  wire crf_op_t reqOpT = crf_op_t'(reqOp);
  wire logic [DC_IDX_W-1:0] hIdxD = dcIdx(reqAddr);
  wire logic [IC_IDX_W-1:0] hIdxI = icIdx(reqAddr);
  wire crf_dstate_t hState = dState[hIdxD];
  wire logic dHit = hState[0] && (dTag[hIdxD] == tagOf(reqAddr));
  wire logic iHit = iValid[hIdxI] && (iTag[hIdxI] == tagOf(reqAddr));
  wire logic [DC_LINE_W-1:0] hLine = dData[hIdxD];
  wire logic [DW_W-1:0] hDw = hLine[int'(reqAddr[DW_SEL_LSB])*DW_W +: DW_W];
  wire logic [IC_LINE_W-1:0] hILine = iData[hIdxI];
  wire logic [DW_W-1:0] hIDw = hILine[int'(reqAddr[4:3])*DW_W +: DW_W];
  wire logic isIdle = (state_reg == CRF_IDLE);
  wire logic accept = ce && reqValid && reqReady_reg;
  wire logic isFetchReq = (reqOpT == CRF_FETCH);
  wire logic reqHit = isFetchReq ? iHit : dHit;
  wire logic reqMiss = accept && (reqOpT != CRF_WBACK) && !reqHit;
  wire logic storeHit = accept && (reqOpT == CRF_STORE) && dHit;
  wire logic wbackReq = accept && (reqOpT == CRF_WBACK);
  wire logic wbackDirty = wbackReq && (hState == CRF_DIRTY);

  ////////////////////////////////////////////////////////////////
  // refill decode
  wire logic isFetch = (op_reg == CRF_FETCH);
  wire logic isStore = (op_reg == CRF_STORE);
  wire logic [DC_IDX_W-1:0] vIdx = dcIdx(addr_reg);
  wire logic [IC_IDX_W-1:0] fIdx = icIdx(addr_reg);
  wire logic leadStart = (state_reg == CRF_LEAD) && (lead_reg == 3'h0);
  wire logic [2:0] leadLast = isFetch ? 3'(IC_LEAD_CYC - 1) : 3'(DC_LEAD_CYC - 1);
  wire logic [3:0] lastBeat = (isFetch ? IC_WORDS_4 : DC_WORDS_4) - 4'h1;
  wire logic [1:0] critW = {addr_reg[DW_SEL_LSB], 1'b0};
  wire logic [2:0] slot = isFetch ? beat_reg[2:0] : {1'b0, critW + beat_reg[1:0]};
  wire logic beatIn = (state_reg == CRF_FILL) && memBeatValid;
  wire logic critDone = beatIn && !isFetch && (beat_reg == 4'h1);
  wire logic [DW_W-1:0] critDw = line_reg[int'(addr_reg[DW_SEL_LSB])*DW_W +: DW_W];
  wire logic [DW_W-1:0] fetchDw = line_reg[int'(addr_reg[4:3])*DW_W +: DW_W];

  ////////////////////////////////////////////////////////////////
  // byte merge, shared by store hits and store misses
  wire logic [DW_W-1:0] mergeOld = isIdle ? hDw : critDw;
  wire logic [DW_W-1:0] mergeNew = isIdle ? reqWdata : wdata_reg;
  wire logic [BE_W-1:0] mergeBe = isIdle ? reqBe : be_reg;
  logic [DW_W-1:0] mergedDw;

  crf_dw_merge u_merge (
    .oldDw(mergeOld),
    .newDw(mergeNew),
    .byteEn(mergeBe),
    .mergedDw(mergedDw)
  );

  wire logic [DC_LINE_W-1:0] fillLine = line_reg[DC_LINE_W-1:0];
  wire logic [DC_LINE_W-1:0] mergedLine = addr_reg[DW_SEL_LSB] ?
      {mergedDw, fillLine[DW_W-1:0]} : {fillLine[DC_LINE_W-1:DW_W], mergedDw};
  wire logic [DC_LINE_W-1:0] newLine = isStore ? mergedLine : fillLine;

  ////////////////////////////////////////////////////////////////
  // flush buffer feed
  wire logic writeSt = (state_reg == CRF_WRITE);
  wire logic victimDirty = (dState[vIdx] == CRF_DIRTY);
  wire logic fbVictim = leadStart && !isFetch && victimDirty;
  wire logic fbStoreOut = writeSt && isStore && !victimDirty_reg;
  wire logic fbLoad = fbVictim || fbStoreOut || wbackDirty;
  logic [PADDR_W-1:0] fbAddr;
  logic [DC_LINE_W-1:0] fbLine;
  logic fbFull;

  always_comb begin
    fbAddr = lineAddr(dTag[vIdx], vIdx);
    fbLine = dData[vIdx];
    if (fbStoreOut) begin
      fbAddr = {addr_reg[PADDR_W-1:DC_IDX_LSB], 4'h0};
      fbLine = mergedLine;
    end else if (wbackDirty) begin
      fbAddr = lineAddr(dTag[hIdxD], hIdxD);
      fbLine = hLine;
    end
  end

  crf_flush_buf #(
    .WORDS(DC_WORDS)
  ) u_flush (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .load(fbLoad),
    .loadAddr(fbAddr),
    .loadLine(fbLine),
    .go(state_reg == CRF_FLUSH),
    .full(fbFull),
    .wbValid(wbValid),
    .wbAddr(wbAddr),
    .wbData(wbData),
    .wbAccept(wbAccept)
  );

  ////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      CRF_IDLE: begin
        if (reqMiss) stateNext = CRF_LEAD;
        else if (wbackDirty) stateNext = CRF_FLUSH;
      end
      CRF_LEAD: if (lead_reg == leadLast) stateNext = CRF_ALIGN;
      CRF_ALIGN: if (sysClkEdge) stateNext = CRF_FILL;
      CRF_FILL: if (memBeatValid && beat_reg == lastBeat) stateNext = CRF_WRITE;
      CRF_WRITE: begin
        if (!isFetch && (victimDirty_reg || isStore)) stateNext = CRF_FLUSH;
        else stateNext = CRF_IDLE;
      end
      CRF_FLUSH: if (!fbFull) stateNext = CRF_IDLE;
      default: stateNext = CRF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= CRF_IDLE;
      reqReady_reg <= 1'b0;
      lead_reg <= 3'h0;
      beat_reg <= 4'h0;
    end else if (ce) begin
      state_reg <= stateNext;
      reqReady_reg <= (stateNext == CRF_IDLE);
      lead_reg <= (state_reg == CRF_LEAD) ? lead_reg + 3'h1 : 3'h0;
      if (state_reg != CRF_FILL) beat_reg <= 4'h0;
      else if (memBeatValid) beat_reg <= beat_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (accept) begin
        op_reg <= reqOpT;
        addr_reg <= reqAddr;
        wdata_reg <= reqWdata;
        be_reg <= reqBe;
      end
      if (leadStart) victimDirty_reg <= !isFetch && victimDirty;
      if (beatIn) line_reg[int'(slot)*WORD_W +: WORD_W] <= memBeatData;
    end
  end

  ////////////////////////////////////////////////////////////////
  // memory read request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memRead_reg <= 1'b0;
      memAddr_reg <= '0;
      memWords_reg <= 4'h0;
    end else if (ce) begin
      memRead_reg <= (state_reg == CRF_ALIGN) && sysClkEdge;
      if (reqMiss) begin
        memAddr_reg <= isFetchReq ? {reqAddr[PADDR_W-1:IC_IDX_LSB], 5'h00}
                                  : {reqAddr[PADDR_W-1:DW_SEL_LSB], 3'h0};
        memWords_reg <= isFetchReq ? IC_WORDS_4 : DC_WORDS_4;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // restart and answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      critPend_reg <= 1'b0;
      rspValid_reg <= 1'b0;
      rspData_reg <= '0;
      restarted_reg <= 1'b0;
      penCnt_reg <= '0;
      missPenalty_reg <= '0;
    end else if (ce) begin
      critPend_reg <= critDone;
      rspValid_reg <= 1'b0;
      if (accept && !wbackReq && reqHit) begin
        rspValid_reg <= (reqOpT != CRF_STORE);
        rspData_reg <= isFetchReq ? hIDw : hDw;
      end else if (critPend_reg) begin
        rspValid_reg <= 1'b1;
        rspData_reg <= critDw;
      end else if (writeSt && isFetch) begin
        rspValid_reg <= 1'b1;
        rspData_reg <= fetchDw;
      end
      if (reqMiss) begin
        penCnt_reg <= PEN_TAIL;
        restarted_reg <= 1'b0;
      end else if (!isIdle && !restarted_reg) begin
        penCnt_reg <= penCnt_reg + PEN_TAIL;
      end
      if (critPend_reg || (writeSt && isFetch)) begin
        restarted_reg <= 1'b1;
        missPenalty_reg <= penCnt_reg + PEN_TAIL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // array updates
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (storeHit) begin
        dData[hIdxD][int'(reqAddr[DW_SEL_LSB])*DW_W +: DW_W] <= mergedDw;
        dState[hIdxD] <= CRF_DIRTY;
      end else if (wbackReq) begin
        dState[hIdxD] <= CRF_INV;
      end else if (writeSt && !isFetch) begin
        dData[vIdx] <= newLine;
        dTag[vIdx] <= tagOf(addr_reg);
        dState[vIdx] <= (isStore && victimDirty_reg) ? CRF_DIRTY : CRF_CLEAN;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce && writeSt && isFetch) begin
      iData[fIdx] <= line_reg;
      iTag[fIdx] <= tagOf(addr_reg);
      iValid[fIdx] <= 1'b1;
    end
  end

  assign reqReady = reqReady_reg;
  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign missPenalty = missPenalty_reg;
  assign memRead = memRead_reg;
  assign memAddr = memAddr_reg;
  assign memWords = memWords_reg;
endmodule // crf_refill_ctrl
`default_nettype wire

//--- common/crf_pkg.sv
package crf_pkg;
  // address layout
  localparam int PADDR_W = 32;
  localparam int WORD_W = 32;
  localparam int DW_W = 64;
  localparam int BE_W = 8;
  localparam int TAG_W = 20;
  localparam int TAG_LSB = 12;
  localparam int DC_IDX_LSB = 4;
  localparam int IC_IDX_LSB = 5;
  localparam int DW_SEL_LSB = 3;
  localparam int DC_IDX_W_DOC = 9;
  localparam int IC_IDX_W_DOC = 9;
  // line lengths in words
  localparam int DC_WORDS = 4;
  localparam int IC_WORDS = 8;
  localparam int DC_LINE_W = DC_WORDS * WORD_W;
  localparam int IC_LINE_W = IC_WORDS * WORD_W;
  // fixed parts of the miss penalty, pipeline cycles
  localparam int DC_LEAD_CYC = 3;
  localparam int IC_LEAD_CYC = 4;
  localparam int PEN_W = 16;
  localparam logic [PEN_W-1:0] PEN_TAIL = 16'h0001;
  localparam logic [3:0] DC_WORDS_4 = 4'h4;
  localparam logic [3:0] IC_WORDS_4 = 4'h8;

  typedef enum logic [1:0] {
    CRF_INV = 2'h0,
    CRF_CLEAN = 2'h1,
    CRF_DIRTY = 2'h3
  } crf_dstate_t;

  typedef enum logic [1:0] {
    CRF_LOAD = 2'h0,
    CRF_STORE = 2'h1,
    CRF_FETCH = 2'h2,
    CRF_WBACK = 2'h3
  } crf_op_t;

  typedef enum logic [5:0] {
    CRF_IDLE = 6'h01,
    CRF_LEAD = 6'h02,
    CRF_ALIGN = 6'h04,
    CRF_FILL = 6'h08,
    CRF_WRITE = 6'h10,
    CRF_FLUSH = 6'h20
  } crf_fsm_t;
endpackage

//--- logic/crf_dw_merge.sv
`timescale 1ns/1ps
`default_nettype none
module crf_dw_merge
  import crf_pkg::*;
(
  // doubleword inputs
  input wire logic [DW_W-1:0] oldDw,
  input wire logic [DW_W-1:0] newDw,
  input wire logic [BE_W-1:0] byteEn,
  // merged doubleword
  output logic [DW_W-1:0] mergedDw
);
  always_comb begin
    for (int b = 0; b < BE_W; b++) begin
      mergedDw[b*8 +: 8] = byteEn[b] ? newDw[b*8 +: 8] : oldDw[b*8 +: 8];
    end
  end
endmodule // crf_dw_merge
`default_nettype wire

//--- logic/crf_flush_buf.sv
`timescale 1ns/1ps
`default_nettype none
module crf_flush_buf
  import crf_pkg::*;
#(
  parameter int WORDS = DC_WORDS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // line capture
  input wire logic load,
  input wire logic [PADDR_W-1:0] loadAddr,
  input wire logic [WORDS*WORD_W-1:0] loadLine,
  input wire logic go,
  output logic full,
  // write-back words toward memory
  output logic wbValid,
  output logic [PADDR_W-1:0] wbAddr,
  output logic [WORD_W-1:0] wbData,
  input wire logic wbAccept
);
  localparam int CW = $clog2(WORDS);
  initial if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) $error("WORDS must be a power of two");

  logic [WORDS*WORD_W-1:0] line_reg;
  logic [PADDR_W-1:0] addr_reg;
  logic [CW-1:0] cnt_reg;
  logic full_reg, wbValid_reg;
  logic [PADDR_W-1:0] wbAddr_reg;
  logic [WORD_W-1:0] wbData_reg;
  wire logic lastWord = (cnt_reg == CW'(WORDS - 1));
  wire logic present = full_reg && go && !wbValid_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_reg <= 1'b0;
      wbValid_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (load) begin
        full_reg <= 1'b1;
        cnt_reg <= '0;
      end else if (wbValid_reg && wbAccept) begin
        wbValid_reg <= 1'b0;
        cnt_reg <= cnt_reg + 1'b1;
        if (lastWord) full_reg <= 1'b0;
      end else if (present) begin
        wbValid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (load) begin
        line_reg <= loadLine;
        addr_reg <= loadAddr;
      end
      if (present) begin
        wbData_reg <= line_reg[int'(cnt_reg)*WORD_W +: WORD_W];
        wbAddr_reg <= addr_reg | PADDR_W'({cnt_reg, 2'b00});
      end
    end
  end

  assign full = full_reg;
  assign wbValid = wbValid_reg;
  assign wbAddr = wbAddr_reg;
  assign wbData = wbData_reg;
endmodule // crf_flush_buf
`default_nettype wire

//--- verif/crf_refill_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module crf_refill_ctrl_chk
  import crf_pkg::*;
#(
  parameter int DC_IDX_W = DC_IDX_W_DOC,
  parameter int IC_IDX_W = IC_IDX_W_DOC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pipeline side
  input wire logic reqReady,
  input wire logic rspValid,
  // memory side
  input wire logic sysClkEdge,
  input wire logic memRead,
  input wire logic [PADDR_W-1:0] memAddr,
  input wire logic [3:0] memWords,
  input wire logic memBeatValid,
  // write-back side
  input wire logic wbValid,
  input wire logic [PADDR_W-1:0] wbAddr,
  input wire logic [WORD_W-1:0] wbData,
  input wire logic wbAccept
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] beatCnt;
  // beats seen since the last line read
  always_ff @(posedge sys_clk) begin
    if (rst || memRead) begin
      beatCnt <= 4'h0;
    end else if (memBeatValid && beatCnt != 4'hF) begin
      beatCnt <= beatCnt + 4'h1;
    end
  end
  ////////////////////////////////////////
  AST_READ_ALIGNED: assert property ($rose(memRead) |-> $past(sysClkEdge))
    else $error("line read off a system clock boundary");
  AST_READ_PULSE: assert property (memRead |=> !memRead)
    else $error("line read longer than one cycle");
  AST_READ_SHAPE: assert property (memRead |=> (memWords == DC_WORDS_4 && memAddr[2:0] == 3'h0)
    || (memWords == IC_WORDS_4 && memAddr[4:0] == 5'h00))
    else $error("line read size or alignment wrong");
  AST_READ_INTERLOCK: assert property (memRead |-> !reqReady)
    else $error("pipeline open during a line read");
  AST_LEAD_WAIT: assert property ($fell(reqReady) |-> !memRead [*3])
    else $error("line read inside the lead cycles");
  AST_CRIT_RESTART: assert property (rspValid && !reqReady && memWords == DC_WORDS_4
    |-> $past(beatCnt) == 4'h2)
    else $error("data restart not on the critical doubleword");
  AST_FETCH_WHOLE: assert property (rspValid && !$past(reqReady) && memWords == IC_WORDS_4
    |-> $past(beatCnt) == 4'h8)
    else $error("fetch restart before the whole line");
  AST_WB_HOLD: assert property (wbValid && !wbAccept
    |=> wbValid && $stable(wbAddr) && $stable(wbData))
    else $error("write-back word changed before accept");
  AST_WB_GAP: assert property (wbValid && wbAccept |=> !wbValid)
    else $error("write-back valid not dropped after accept");
  AST_WB_BUSY: assert property (wbValid |-> !reqReady)
    else $error("write-back while pipeline open");
  cover property (memRead ##1 memWords == DC_WORDS_4);
  cover property (memRead ##1 memWords == IC_WORDS_4);
  cover property (wbValid && wbAccept);
endmodule // crf_refill_ctrl_chk
bind crf_refill_ctrl crf_refill_ctrl_chk #(
  .DC_IDX_W(DC_IDX_W),
  .IC_IDX_W(IC_IDX_W)
) crf_chk (
  .sys_clk(sys_clk), .rst(rst), .reqReady(reqReady), .rspValid(rspValid),
  .sysClkEdge(sysClkEdge), .memRead(memRead), .memAddr(memAddr), .memWords(memWords),
  .memBeatValid(memBeatValid), .wbValid(wbValid), .wbAddr(wbAddr), .wbData(wbData),
  .wbAccept(wbAccept)
);
`default_nettype wire

//--- verif/crf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model
  import crf_pkg::*;
(
  // clock and pacing knobs
  input wire logic sys_clk,
  input wire logic [7:0] lat,
  input wire logic [3:0] gap,
  input wire logic [3:0] sysDiv,
  input wire logic [3:0] wbDly,
  // line read
  output logic sysClkEdge,
  input wire logic memRead,
  input wire logic [PADDR_W-1:0] memAddr,
  input wire logic [3:0] memWords,
  output logic memBeatValid,
  output logic [WORD_W-1:0] memBeatData,
  // write-back
  input wire logic wbValid,
  input wire logic [PADDR_W-1:0] wbAddr,
  input wire logic [WORD_W-1:0] wbData,
  output logic wbAccept
);
  logic [WORD_W-1:0] mem [logic [PADDR_W-1:0]];
  logic [3:0] sc = 4'h0;
  logic [3:0] wc = 4'h0;
  int wbN = 0;
  function automatic logic [WORD_W-1:0] rd(input logic [PADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : a ^ {a[15:0], a[31:16]} ^ 32'h5A5AC3C3;
  endfunction
  ////////////////////////////////////////
  // boundary marker every sysDiv cycles
  always @(posedge sys_clk) begin
    sc <= (sc + 4'h1 >= sysDiv) ? 4'h0 : sc + 4'h1;
    sysClkEdge <= (sc + 4'h1 >= sysDiv);
  end
  initial begin
    logic [PADDR_W-1:0] a;
    logic [PADDR_W-1:0] wa;
    logic [3:0] w;
    memBeatValid = 1'b0;
    memBeatData = 32'h0;
    forever begin
      @(posedge sys_clk);
      if (memRead === 1'b1) begin
        @(posedge sys_clk);
        a = memAddr;
        w = memWords;
        repeat (lat) @(posedge sys_clk);
        for (int i = 0; i < int'(w); i++) begin
          wa = (w == IC_WORDS_4 || i < 2) ? a + PADDR_W'(4 * i) : (a ^ 32'h8) + PADDR_W'(4 * i - 8);
          memBeatValid <= 1'b1;
          memBeatData <= rd(wa);
          @(posedge sys_clk);
          // released bus shows the inverse, never a stale word
          if (gap != 4'h0 || i == int'(w) - 1) begin
            memBeatValid <= 1'b0;
            memBeatData <= ~rd(wa);
            repeat (gap) @(posedge sys_clk);
          end
        end
      end
    end
  end
  // write-back words taken after wbDly waiting cycles
  always @(posedge sys_clk) begin
    if (wbValid === 1'b1 && wbAccept) begin
      mem[wbAddr] = wbData;
      wbN <= wbN + 1;
      wbAccept <= 1'b0;
      wc <= 4'h0;
    end else if (wbValid === 1'b1) begin
      wbAccept <= (wc >= wbDly);
      wc <= wc + 4'h1;
    end else begin
      wbAccept <= 1'b0;
      wc <= 4'h0;
    end
  end
endmodule // crf_mem_model
`default_nettype wire

//--- verif/tb_cache_line_refill_writeback.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cache_line_refill_writeback;
  import crf_pkg::*;
  localparam logic [31:0] A1 = 32'h00010040;
  localparam logic [31:0] A2 = 32'h00020040;
  localparam logic [31:0] A3 = 32'h00030040;
  localparam logic [31:0] B1 = 32'h00010080;
  localparam logic [31:0] C1 = 32'h00040100;
  localparam logic [63:0] WD = 64'h1122334455667788;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reqValid = 1'b0;
  logic [1:0] reqOp = 2'h0;
  logic [31:0] reqAddr = 32'h0;
  logic [63:0] reqWdata = 64'h0;
  logic [7:0] reqBe = 8'h00;
  logic reqReady, rspValid, memRead, memBeatValid, wbValid, wbAccept, sysClkEdge;
  logic [63:0] rspData, rsp, e1, e2;
  logic [PEN_W-1:0] missPenalty, p1;
  logic [31:0] memAddr, wbAddr, memBeatData, wbData;
  logic [3:0] memWords;
  logic [7:0] lat = 8'h02;
  logic [3:0] gap = 4'h0, sysDiv = 4'h1, wbDly = 4'h0;
  int failures = 0, comparisons = 0, nRd = 0, nRsp = 0, r0, s0, w0;
  crf_refill_ctrl dut (
    .sys_clk, .rst, .ce, .reqValid, .reqOp, .reqAddr, .reqWdata, .reqBe, .reqReady,
    .rspValid, .rspData, .missPenalty, .sysClkEdge, .memRead, .memAddr, .memWords,
    .memBeatValid, .memBeatData, .wbValid, .wbAddr, .wbData, .wbAccept
  );
  crf_mem_model mdl (
    .sys_clk, .lat, .gap, .sysDiv, .wbDly, .sysClkEdge, .memRead, .memAddr, .memWords,
    .memBeatValid, .memBeatData, .wbValid, .wbAddr, .wbData, .wbAccept
  );
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (memRead === 1'b1) nRd <= nRd + 1;
    if (rspValid === 1'b1) begin
      nRsp <= nRsp + 1;
      rsp <= rspData;
    end
  end
  ////////////////////////////////////////
  function automatic logic [63:0] dw(input logic [31:0] a);
    return {mdl.rd({a[31:3], 3'h4}), mdl.rd({a[31:3], 3'h0})};
  endfunction
  function automatic logic [63:0] mrg(input logic [63:0] o, n, input logic [7:0] be);
    for (int b = 0; b < 8; b++) begin
      if (be[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request, held until taken, then wait for idle
  task automatic access(input logic [1:0] op, input logic [31:0] a, input logic [7:0] be);
    r0 = nRd;
    s0 = nRsp;
    w0 = mdl.wbN;
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = a;
    reqWdata = WD;
    reqBe = be;
    repeat (2000) if (reqReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    repeat (2000) if (reqReady !== 1'b1) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic delta(input int dr, input int ds, input int dwb);
    chk("line reads", 64'(r0 + dr), 64'(nRd));
    chk("answers", 64'(s0 + ds), 64'(nRsp));
    chk("write-back words", 64'(w0 + dwb), 64'(mdl.wbN));
  endtask
  ////////////////////////////////////////
  task automatic t_load_miss;
    access(2'h3, A1, 8'h00);
    access(2'h3, B1, 8'h00);
    access(2'h0, A1 | 32'h8, 8'h00);
    delta(1, 1, 0);
    chk("miss data", dw(A1 | 32'h8), rsp);
    chk("read address", 64'(A1 | 32'h8), 64'(memAddr));
    p1 = missPenalty;
    access(2'h3, A1, 8'h00);
    delta(0, 0, 0);
    lat = 8'h04;
    access(2'h0, A1 | 32'h8, 8'h00);
    chk("penalty step", 64'(p1 + 16'h0002), 64'(missPenalty));
    lat = 8'h02;
    access(2'h0, A1, 8'h00);
    delta(0, 1, 0);
    chk("hit data", dw(A1), rsp);
  endtask
  task automatic t_store_miss;
    sysDiv = 4'h3;
    gap = 4'h1;
    wbDly = 4'h2;
    e1 = mrg(dw(B1), WD, 8'h30);
    access(2'h1, B1 | 32'h4, 8'h30);
    delta(1, 1, 4);
    chk("stored word", 64'(e1[63:32]), 64'(mdl.rd(B1 | 32'h4)));
    access(2'h0, B1, 8'h00);
    delta(0, 1, 0);
    chk("merged line", e1, rsp);
  endtask
  task automatic t_dirty;
    e1 = mrg(dw(A1), WD, 8'h0F);
    access(2'h1, A1, 8'h0F);
    delta(0, 0, 0);
    access(2'h0, A2, 8'h00);
    delta(1, 1, 4);
    chk("flushed word", 64'(e1[31:0]), 64'(mdl.rd(A1)));
    chk("refill data", dw(A2), rsp);
    access(2'h1, A2, 8'hF0);
    delta(0, 0, 0);
    e2 = mrg(dw(A3), WD, 8'h0F);
    access(2'h1, A3, 8'h0F);
    delta(1, 1, 4);
    chk("victim word", 64'(WD[63:32]), 64'(mdl.rd(A2 | 32'h4)));
    access(2'h3, A3, 8'h00);
    delta(0, 0, 4);
    chk("written back", 64'(e2[31:0]), 64'(mdl.rd(A3)));
    access(2'h0, A3, 8'h00);
    delta(1, 1, 0);
    chk("reloaded", e2, rsp);
  endtask
  task automatic t_fetch;
    sysDiv = 4'h1;
    gap = 4'h0;
    wbDly = 4'h0;
    access(2'h2, C1 | 32'h14, 8'h00);
    delta(1, 1, 0);
    chk("fetch data", dw(C1 | 32'h14), rsp);
    chk("fetch read", 64'(C1), 64'(memAddr));
    chk("fetch penalty", 64'(p1 + 16'h0007), 64'(missPenalty));
    access(2'h2, C1, 8'h00);
    delta(0, 1, 0);
    chk("fetch hit", dw(C1), rsp);
  endtask
  task automatic t_reset_keep;
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    access(2'h0, A3, 8'h00);
    delta(0, 1, 0);
    chk("kept line", e2, rsp);
    access(2'h2, C1 | 32'h8, 8'h00);
    delta(0, 1, 0);
    ce = 1'b0;
    access(2'h0, A3, 8'h00);
    delta(0, 0, 0);
    ce = 1'b1;
  endtask
  task automatic print_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    t_load_miss();
    t_store_miss();
    t_dirty();
    t_fetch();
    t_reset_keep();
    print_verdict();
  end
endmodule // tb_cache_line_refill_writeback
`default_nettype wire
